// [dv/host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ************************
// host bus master model
// ************************
module host_model (
  // clock
  input wire logic ref_clk,
  // register pins
  output logic chip_select,
  output logic write_strobe,
  output logic read_strobe,
  output logic address_strobe,
  output logic serial_not_dma,
  output logic data_not_control,
  output logic [4:0] bus_address,
  output logic [15:0] write_data,
  input wire logic [15:0] read_data
);
  initial begin
    chip_select = 1'b0;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    address_strobe = 1'b0; // never pulsed: bus stays non-multiplexed
    serial_not_dma = 1'b1;
    data_not_control = 1'b0;
    bus_address = 5'h00;
    write_data = 16'h0000;
  end
  // strobe held 5 edges: sync takes 2, read data lands one later
  task automatic cycle(input bit rd, input logic dc, input logic [4:0] a,
                       input logic [15:0] d, output logic [15:0] q);
    @(posedge ref_clk);
    #1;
    chip_select = 1'b1;
    read_strobe = rd;
    write_strobe = !rd;
    serial_not_dma = 1'b0;
    data_not_control = dc;
    bus_address = a;
    write_data = d;
    repeat (5) @(posedge ref_clk);
    q = read_data;
    #1;
    chip_select = 1'b0;
    read_strobe = 1'b0;
    write_strobe = 1'b0;
    serial_not_dma = 1'b1;
    bus_address = ~a;
    write_data = ~d; // released lines do not keep the old value
    repeat (2) @(posedge ref_clk);
  endtask
  // pointer first, reserved pointer bits written as zero
  task automatic reg_access(input bit rd, input logic dc, input logic [4:0] a,
                            input logic [15:0] d, output logic [15:0] q);
    cycle(1'b0, dc, 5'h00, {10'h000, a, 1'b0}, q);
    cycle(rd, dc, a, d, q);
  endtask
endmodule // host_model
`default_nettype wire

// [dv/test_dma_register_decode_and_dwell.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dma_regs_defs.svh"
// ************************
// register and dwell tests
// ************************
module test_dma_register_decode_and_dwell;
  logic ref_clk, reset, bus_granted, transfer_start, transfer_done;
  logic [3:0] tx_array_count;
  wire logic chip_select, write_strobe, read_strobe, address_strobe;
  wire logic serial_not_dma, data_not_control, release_bus, configured, muxed_bus;
  wire logic byte_order_little, irq_clear_pulse, irq_set_pulse;
  wire logic [4:0] bus_address;
  wire logic [15:0] write_data, read_data, bus_config;
  logic [15:0] q;
  logic [4:0] chan [8] = '{`A_MODE, `A_ARM, `A_COUNT, `A_ADDRLO, `A_ADDRHI,
                          `A_NCOUNT, `A_NADDRLO, `A_NADDRHI};
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_clr = 0;
  int n_set = 0;
  host_model host (.ref_clk(ref_clk), .chip_select(chip_select),
    .write_strobe(write_strobe), .read_strobe(read_strobe),
    .address_strobe(address_strobe), .serial_not_dma(serial_not_dma),
    .data_not_control(data_not_control), .bus_address(bus_address),
    .write_data(write_data), .read_data(read_data));
  dma_register_decode_and_dwell dut (.ref_clk(ref_clk), .reset(reset),
    .chip_select(chip_select), .write_strobe(write_strobe), .read_strobe(read_strobe),
    .address_strobe(address_strobe), .serial_not_dma(serial_not_dma),
    .data_not_control(data_not_control), .bus_address(bus_address),
    .write_data(write_data), .read_data(read_data), .bus_granted(bus_granted),
    .transfer_start(transfer_start), .transfer_done(transfer_done),
    .tx_array_count(tx_array_count), .release_bus(release_bus),
    .configured(configured), .muxed_bus(muxed_bus),
    .byte_order_little(byte_order_little), .irq_clear_pulse(irq_clear_pulse),
    .irq_set_pulse(irq_set_pulse), .bus_config(bus_config));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    n_clr <= n_clr + (irq_clear_pulse === 1'b1);
    n_set <= n_set + (irq_set_pulse === 1'b1);
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wait_release(input int lim);
    int i;
    for (i = 0; i < lim && release_bus !== 1'b1; i++) @(posedge ref_clk);
    check("release_bus", 16'h0001, {15'h0000, i < lim});
    if (i == lim) give_verdict();
  endtask
  // one bus transfer; done held 3 edges so the synchroniser sees it
  task automatic transfer(input int stretch);
    @(posedge ref_clk);
    #1 transfer_start = 1'b1;
    @(posedge ref_clk);
    #1 transfer_start = 1'b0;
    repeat (stretch) @(posedge ref_clk);
    check("release mid cycle", 16'h0000, {15'h0000, release_bus});
    #1 transfer_done = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 transfer_done = 1'b0;
  endtask
  initial begin
    reset = 1'b1;
    bus_granted = 1'b0;
    transfer_start = 1'b0;
    transfer_done = 1'b0;
    tx_array_count = 4'h9;
    repeat (16) @(posedge ref_clk);
    #1 reset = 1'b0;
    host.cycle(1'b0, 1'b0, 5'h13, 16'h0001, q);
    check("bus_config", 16'h0001, bus_config);
    check("muxed_bus", 16'h0000, {15'h0000, muxed_bus});
    check("configured", 16'h0001, {15'h0000, configured});
    $display("test config done");
    for (int i = 0; i < 8; i++) begin
      host.reg_access(1'b0, 1'b0, chan[i], 16'h1230 + i, q);
      host.reg_access(1'b0, 1'b1, chan[i], 16'hC840 + i, q);
      host.reg_access(1'b1, 1'b0, chan[i], 16'h0000, q);
      check("tx copy", 16'h1230 + i, q);
      host.reg_access(1'b1, 1'b1, chan[i], 16'h0000, q);
      check("rx copy", 16'hC840 + i, q);
    end
    check("bus_config kept", 16'h0001, bus_config);
    $display("test channel copies done");
    host.reg_access(1'b0, 1'b0, `A_CONTROL, 16'h1000, q);
    host.reg_access(1'b1, 1'b1, `A_CONTROL, 16'h0000, q);
    check("dma_control", 16'h1000, q);
    check("byte order", 16'h0001, {15'h0000, byte_order_little});
    host.reg_access(1'b0, 1'b0, `A_ARRAY, 16'hFFFF, q);
    host.reg_access(1'b1, 1'b1, `A_ARRAY, 16'h0000, q);
    check("dma_array_count", 16'h9000, q);
    host.reg_access(1'b0, 1'b0, `A_IRQCLR, 16'h0001, q);
    host.reg_access(1'b0, 1'b1, `A_IRQSET, 16'h0001, q);
    check("clear pulses", 16'h0001, n_clr[15:0]);
    check("set pulses", 16'h0001, n_set[15:0]);
    host.reg_access(1'b0, 1'b1, `A_VECTOR, 16'h00A5, q);
    host.reg_access(1'b1, 1'b0, `A_VECTOR, 16'h0000, q);
    check("dma_irq_vector", 16'h00A5, q);
    host.reg_access(1'b1, 1'b0, `A_IRQCLR, 16'h0000, q);
    check("dma_irq_clear", 16'h0000, q);
    $display("test shared done");
    host.reg_access(1'b0, 1'b0, `A_DWELL, 16'h0200, q);
    #1 bus_granted = 1'b1;
    transfer(2);
    check("release after one", 16'h0000, {15'h0000, release_bus});
    transfer(2);
    wait_release(10);
    #1 bus_granted = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 bus_granted = 1'b1;
    repeat (6) @(posedge ref_clk);
    check("release on regrant", 16'h0000, {15'h0000, release_bus});
    #1 bus_granted = 1'b0;
    host.reg_access(1'b0, 1'b0, `A_DWELL, 16'h0008, q);
    #1 bus_granted = 1'b1;
    transfer(20);
    wait_release(10);
    #1 bus_granted = 1'b0;
    $display("test dwell done");
    host.cycle(1'b0, 1'b0, 5'h00, {10'h000, `A_DWELL, 1'b0}, q);
    host.cycle(1'b1, 1'b0, 5'h00, 16'h0000, q);
    check("indirect read", 16'h0008, q);
    host.cycle(1'b1, 1'b0, 5'h00, 16'h0000, q);
    check("pointer after access", 16'h0000, q);
    $display("test pointer done");
    give_verdict();
  end
endmodule // test_dma_register_decode_and_dwell
`default_nettype wire

// [src/dma_register_decode_and_dwell.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dma_regs_defs.svh"
module dma_register_decode_and_dwell (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // host register port (pins)
  input wire logic chip_select,
  input wire logic write_strobe,
  input wire logic read_strobe,
  input wire logic address_strobe,
  input wire logic serial_not_dma,
  input wire logic data_not_control,
  input wire logic [4:0] bus_address,
  input wire logic [15:0] write_data,
  output logic [15:0] read_data,
  // dma bus ownership
  input wire logic bus_granted,
  input wire logic transfer_start,
  input wire logic transfer_done,
  input wire logic [3:0] tx_array_count,
  output logic release_bus,
  output logic configured,
  output logic muxed_bus,
  output logic byte_order_little,
  output logic irq_clear_pulse,
  output logic irq_set_pulse,
  output logic [15:0] bus_config
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic [4:0] addr1;
  logic [4:0] addr2;
  logic [15:0] wdata1;
  logic [15:0] wdata2;
  logic [3:0] acnt1;
  logic [3:0] acnt2;
  always_ff @(posedge ref_clk) begin
    sync1 <= {chip_select, write_strobe, read_strobe, address_strobe,
              serial_not_dma, data_not_control, bus_granted, transfer_done};
    sync2 <= sync1;
    addr1 <= bus_address;
    addr2 <= addr1;
    wdata1 <= write_data;
    wdata2 <= wdata1;
    acnt1 <= tx_array_count;
    acnt2 <= acnt1;
  end
  wire cs_s = sync2[7];
  wire wr_s = sync2[6];
  wire rd_s = sync2[5];
  wire as_s = sync2[4];
  wire sd_s = sync2[3];
  wire dc_s = sync2[2];
  wire grant_s = sync2[1];
  wire done_s = sync2[0];
  // start request is same-domain logic
  wire start_s = transfer_start;

  // ****************************************
  // access edge detection
  // ****************************************
  logic wr_d;
  logic rd_d;
  always_ff @(posedge ref_clk) begin
    wr_d <= wr_s;
    rd_d <= rd_s;
  end
  wire write_go = cs_s && wr_s && !wr_d;
  wire read_go = cs_s && rd_s && !rd_d;

  // ****************************************
  // register storage
  // ****************************************
  logic [4:0] latched_addr;
  logic [15:0] pointer_reg;
  logic [15:0] control_reg;
  logic [15:0] dwell_reg;
  logic [15:0] vector_reg;
  logic [15:0] irqctl_reg;
  logic [15:0] tx_bank [0:7];
  logic [15:0] rx_bank [0:7];

  // per-channel slot index, 8 means not a per-channel register
  function automatic logic [3:0] slot_of(input logic [4:0] a);
    case (a)
      `A_MODE: slot_of = 4'h0;
      `A_ARM: slot_of = 4'h1;
      `A_COUNT: slot_of = 4'h2;
      `A_ADDRLO: slot_of = 4'h3;
      `A_ADDRHI: slot_of = 4'h4;
      `A_NCOUNT: slot_of = 4'h5;
      `A_NADDRLO: slot_of = 4'h6;
      `A_NADDRHI: slot_of = 4'h7;
      default: slot_of = 4'h8;
    endcase
  endfunction

  // ****************************************
  // address selection
  // ****************************************
  // pointer is used only when no address strobe was seen before the configuration write
  wire [4:0] ptr_addr = pointer_reg[`PTR_MSB:`PTR_LSB];
  wire [4:0] sel_addr = muxed_bus ? latched_addr : ptr_addr; // [R19]
  wire dma_space = !sd_s;
  wire [3:0] slot = slot_of(sel_addr);
  wire per_chan = !slot[3];
  wire [2:0] slot_ix = slot[2:0];
  wire is_pointer = sel_addr == `A_POINTER;
  // non-pointer access through a nonzero pointer consumes it
  wire indirect = !muxed_bus && !is_pointer;
  wire wr_dma = write_go && configured && dma_space;
  wire rd_dma = read_go && configured && dma_space;

  // ****************************************
  // read mux
  // ****************************************
  logic [15:0] next_read_data;
  always_comb begin
    next_read_data = 16'h0000;
    if (per_chan) begin
      next_read_data = dc_s ? rx_bank[slot_ix] : tx_bank[slot_ix]; // [R01]
    end else begin
      case (sel_addr) // [R02]
        `A_POINTER: next_read_data = {8'h00, 2'b00, pointer_reg[5:0]}; // [R04]
        `A_CONTROL: next_read_data = control_reg; // [R03]
        `A_ARRAY: next_read_data = {acnt2, 12'h000}; // [R13] [R07]
        `A_DWELL: next_read_data = dwell_reg;
        `A_VECTOR: next_read_data = vector_reg; // [R17]
        `A_IRQCTL: next_read_data = irqctl_reg;
        // clear/set registers are command only
        default: next_read_data = 16'h0000; // [R04]
      endcase
    end
  end

  // ****************************************
  // register writes
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      configured <= 1'b0;
      muxed_bus <= 1'b0;
      bus_config <= `RESET_WORD;
      latched_addr <= 5'h00;
      pointer_reg <= `RESET_WORD;
      control_reg <= `RESET_WORD;
      dwell_reg <= `RESET_WORD;
      vector_reg <= `RESET_WORD;
      irqctl_reg <= `RESET_WORD;
      read_data <= 16'h0000;
      irq_clear_pulse <= 1'b0;
      irq_set_pulse <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        tx_bank[i] <= `RESET_WORD;
        rx_bank[i] <= `RESET_WORD;
      end
    end else begin
      irq_clear_pulse <= 1'b0;
      irq_set_pulse <= 1'b0;
      if (cs_s && as_s) begin
        latched_addr <= addr2;
        if (!configured) begin
          muxed_bus <= 1'b1;
        end
      end
      if (read_go) begin
        read_data <= (configured && dma_space) ? next_read_data : 16'h0000;
      end
      if (write_go && !configured) begin
        bus_config <= wdata2; // [R18]
        configured <= 1'b1;
      end
      if (wr_dma) begin
        if (per_chan) begin
          if (dc_s) begin // [R01]
            rx_bank[slot_ix] <= wdata2; // [R14] [R15] [R16]
          end else begin
            tx_bank[slot_ix] <= wdata2;
          end
        end else begin
          case (sel_addr) // [R02]
            `A_POINTER: pointer_reg <= wdata2;
            `A_CONTROL: control_reg <= wdata2; // [R03]
            `A_DWELL: dwell_reg <= wdata2;
            `A_VECTOR: vector_reg <= wdata2; // [R17]
            `A_IRQCTL: irqctl_reg <= wdata2;
            `A_IRQCLR: irq_clear_pulse <= 1'b1; // [R04]
            `A_IRQSET: irq_set_pulse <= 1'b1;
            // array count is read-only: writes dropped
            default: irqctl_reg <= irqctl_reg; // [R05]
          endcase
        end
      end
      if ((wr_dma || rd_dma) && indirect) begin
        pointer_reg[`PTR_MSB:`PTR_LSB] <= 5'h00; // [R20] [R06]
      end
    end
  end

  // ****************************************
  // register checks
  // ****************************************
  // bank slots: 0 mode, 1 arm, 7 next address high
  rx_copy_write_a: assert property (@(posedge ref_clk) disable iff (reset) // [R01]
    wr_dma && per_chan && dc_s |=> rx_bank[$past(slot_ix)] == $past(wdata2))
    else $error("receive copy not written");
  tx_untouched_a: assert property (@(posedge ref_clk) disable iff (reset) // [R01]
    wr_dma && per_chan && dc_s |=> tx_bank[$past(slot_ix)] == $past(tx_bank[slot_ix]))
    else $error("receive write touched transmit copy");
  serial_space_a: assert property (@(posedge ref_clk) disable iff (reset) // [R01]
    write_go && configured && sd_s |=> $stable(control_reg) && $stable(pointer_reg))
    else $error("serial space write reached dma registers");
  shared_write_a: assert property (@(posedge ref_clk) disable iff (reset) // [R02]
    wr_dma && sel_addr == `A_CONTROL |=> control_reg == $past(wdata2))
    else $error("shared register write lost");
  control_hold_a: assert property (@(posedge ref_clk) disable iff (reset) // [R03]
    !(wr_dma && sel_addr == `A_CONTROL) |=> $stable(control_reg))
    else $error("control bits changed without host write");
  set_pulse_a: assert property (@(posedge ref_clk) disable iff (reset) // [R04]
    wr_dma && sel_addr == `A_IRQSET |=> irq_set_pulse)
    else $error("set command not started");
  clear_pulse_a: assert property (@(posedge ref_clk) disable iff (reset) // [R04]
    wr_dma && sel_addr == `A_IRQCLR |=> irq_clear_pulse)
    else $error("clear command not started");
  pulse_once_a: assert property (@(posedge ref_clk) disable iff (reset) // [R04]
    irq_clear_pulse || irq_set_pulse |=> !irq_clear_pulse && !irq_set_pulse)
    else $error("command pulse longer than one cycle");
  array_ro_a: assert property (@(posedge ref_clk) disable iff (reset) // [R05]
    wr_dma && sel_addr == `A_ARRAY |=> $stable(control_reg) && $stable(dwell_reg))
    else $error("array count write changed a register");
  array_read_a: assert property (@(posedge ref_clk) disable iff (reset) // [R13] [R07]
    rd_dma && sel_addr == `A_ARRAY |=> read_data == {$past(acnt2), 12'h000})
    else $error("array count read wrong");
  pointer_read_a: assert property (@(posedge ref_clk) disable iff (reset) // [R07]
    rd_dma && sel_addr == `A_POINTER |=> read_data[15:6] == 10'h000)
    else $error("absent pointer bits read nonzero");
  mode_write_a: assert property (@(posedge ref_clk) disable iff (reset) // [R15]
    wr_dma && sel_addr == `A_MODE && !dc_s |=> tx_bank[0] == $past(wdata2))
    else $error("transmit mode not written");
  arm_write_a: assert property (@(posedge ref_clk) disable iff (reset) // [R16]
    wr_dma && sel_addr == `A_ARM && dc_s |=> rx_bank[1] == $past(wdata2))
    else $error("receive arm not written");
  next_high_a: assert property (@(posedge ref_clk) disable iff (reset) // [R14]
    wr_dma && sel_addr == `A_NADDRHI && !dc_s |=> tx_bank[7] == $past(wdata2))
    else $error("next address high not written");
  vector_write_a: assert property (@(posedge ref_clk) disable iff (reset) // [R17]
    wr_dma && sel_addr == `A_VECTOR |=> vector_reg == $past(wdata2))
    else $error("vector not written");
  config_once_a: assert property (@(posedge ref_clk) disable iff (reset) // [R18]
    write_go && configured |=> $stable(bus_config))
    else $error("bus configuration rewritten");
  unconfigured_read_a: assert property (@(posedge ref_clk) disable iff (reset) // [R18]
    read_go && !configured |=> read_data == 16'h0000)
    else $error("read before configuration nonzero");
  pointer_load_a: assert property (@(posedge ref_clk) disable iff (reset) // [R19] [R06]
    wr_dma && is_pointer && !muxed_bus |=> pointer_reg == $past(wdata2))
    else $error("pointer write not kept");

  // ****************************************
  // bus dwell limiting
  // ****************************************
  dma_regs_pkg::dwell_state_t state;
  dma_regs_pkg::dwell_state_t next_state;
  logic [7:0] xfer_count;
  logic [7:0] cycle_count;
  logic in_cycle;
  wire [7:0] xfer_limit = dwell_reg[15:8];
  wire [7:0] cycle_limit = dwell_reg[7:0];
  wire xfer_hit = (xfer_limit != 8'h00) && (xfer_count >= xfer_limit); // [R09]
  wire cycle_hit = (cycle_limit != 8'h00) && (cycle_count >= cycle_limit); // [R10]
  wire limit_hit = xfer_hit || cycle_hit;
  always_comb begin
    next_state = state;
    case (state)
      dma_regs_pkg::idle_s: if (grant_s) next_state = dma_regs_pkg::owning_s;
      dma_regs_pkg::owning_s: begin
        if (!grant_s) begin
          next_state = dma_regs_pkg::idle_s;
        end else if (limit_hit) begin
          next_state = dma_regs_pkg::finishing_s;
        end
      end
      // wait out a stretched cycle before letting go
      dma_regs_pkg::finishing_s: if (!in_cycle && !grant_s) next_state = dma_regs_pkg::idle_s;
      default: next_state = dma_regs_pkg::idle_s;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= dma_regs_pkg::idle_s;
      xfer_count <= 8'h00;
      cycle_count <= 8'h00;
      in_cycle <= 1'b0;
      release_bus <= 1'b0;
      byte_order_little <= 1'b0;
    end else begin
      state <= next_state;
      byte_order_little <= control_reg[`ORDER_BIT]; // [R12]
      if (start_s && !in_cycle) begin
        in_cycle <= 1'b1;
      end else if (done_s) begin
        in_cycle <= 1'b0;
      end
      if (state == dma_regs_pkg::idle_s) begin
        xfer_count <= 8'h00; // [R21]
        cycle_count <= 8'h00;
      end else begin
        if (cycle_count != 8'hFF) cycle_count <= cycle_count + 8'h01;
        if (done_s && in_cycle && xfer_count != 8'hFF) xfer_count <= xfer_count + 8'h01;
      end
      // release only between cycles
      release_bus <= (state != dma_regs_pkg::idle_s) && limit_hit && !(in_cycle && !done_s); // [R11]
    end
  end

  // ****************************************
  // checks
  // ****************************************
  read_zero_a: assert property (@(posedge ref_clk) disable iff (reset) // [R04]
    read_go && configured && dma_space && sel_addr == `A_IRQCLR |=> read_data == 16'h0000)
    else $error("command register read nonzero");
  cycle_done_a: assert property (@(posedge ref_clk) disable iff (reset) // [R11]
    in_cycle && !done_s |=> !release_bus)
    else $error("bus released mid cycle");
  first_write_a: assert property (@(posedge ref_clk) disable iff (reset) // [R18]
    write_go && !configured |=> configured && bus_config == $past(wdata2))
    else $error("first write not taken as configuration");
  counter_restart_a: assert property (@(posedge ref_clk) disable iff (reset) // [R21]
    state == dma_regs_pkg::idle_s |=> xfer_count == 8'h00 && cycle_count == 8'h00)
    else $error("dwell counters not restarted");
  xfer_off_a: assert property (@(posedge ref_clk) disable iff (reset) // [R09]
    dwell_reg == 16'h0000 |-> !limit_hit)
    else $error("zero limit still limits");
  pointer_clear_a: assert property (@(posedge ref_clk) disable iff (reset) // [R20]
    (wr_dma || rd_dma) && indirect |=> ptr_addr == 5'h00)
    else $error("pointer not cleared after access");
  order_bit_a: assert property (@(posedge ref_clk) disable iff (reset) // [R12]
    ##1 byte_order_little == $past(control_reg[`ORDER_BIT]))
    else $error("byte order not following control");
  channel_sel_a: assert property (@(posedge ref_clk) disable iff (reset) // [R01]
    wr_dma && per_chan && !dc_s |=> tx_bank[$past(slot_ix)] == $past(wdata2))
    else $error("transmit copy not written");
  // limits bite only between bus cycles
  xfer_release_a: assert property (@(posedge ref_clk) disable iff (reset) // [R09]
    state != dma_regs_pkg::idle_s && xfer_hit && !in_cycle |=> release_bus)
    else $error("transfer limit not releasing bus");
  xfer_count_a: assert property (@(posedge ref_clk) disable iff (reset) // [R09]
    state != dma_regs_pkg::idle_s && done_s && in_cycle && xfer_count != 8'hFF
    |=> xfer_count == $past(xfer_count) + 8'h01)
    else $error("transfer not counted");
  cycle_release_a: assert property (@(posedge ref_clk) disable iff (reset) // [R10]
    state != dma_regs_pkg::idle_s && cycle_hit && !in_cycle |=> release_bus)
    else $error("cycle limit not releasing bus");
  cycle_count_a: assert property (@(posedge ref_clk) disable iff (reset) // [R10]
    state != dma_regs_pkg::idle_s && cycle_count != 8'hFF
    |=> cycle_count == $past(cycle_count) + 8'h01)
    else $error("owned cycle not counted");
  no_limit_a: assert property (@(posedge ref_clk) disable iff (reset) // [R09] [R10]
    !limit_hit |=> !release_bus)
    else $error("bus released below limits");
  finish_hold_a: assert property (@(posedge ref_clk) disable iff (reset) // [R11]
    state == dma_regs_pkg::finishing_s && in_cycle && !done_s
    |=> state == dma_regs_pkg::finishing_s)
    else $error("finishing left during bus cycle");
  idle_release_a: assert property (@(posedge ref_clk) disable iff (reset) // [R21]
    state == dma_regs_pkg::idle_s |=> !release_bus)
    else $error("release while bus not owned");
  grant_owning_a: assert property (@(posedge ref_clk) disable iff (reset) // [R21]
    state == dma_regs_pkg::idle_s && grant_s
    |=> state == dma_regs_pkg::owning_s && xfer_count == 8'h00 && cycle_count == 8'h00)
    else $error("new tenure started with stale counts");
endmodule // dma_register_decode_and_dwell
`default_nettype wire

// [src/dma_regs_defs.svh]
// What this block does
// R01 - low select picks transmit, high picks receive
// R02 - shared registers ignore the data/control select
// R03 - control bits host owned, never changed by hardware
// R04 - command bits act on write, read zero
// R05 - host writes to status bits ignored
// R06 - command/status bits writable, readable, hardware updated
// R07 - absent reserved bits read zero
// R08 - host writes zeros to reserved bits
// R09 - upper dwell byte limits transfers, zero disables
// R10 - lower dwell byte limits bus cycles
// R11 - bus cycle in progress always completes
// R12 - control bit 12 selects fetched byte order
// R13 - array count at 00100, transmit count read-only
// R14 - byte count, address, next registers decode
// R15 - mode registers decode at 00001
// R16 - interrupt arm registers decode at 01111
// R17 - shared interrupt registers decode at listed addresses
// R18 - first write after reset loads bus configuration
// R19 - address from latched bus or pointer field
// R20 - pointer clears after one indirect access
// R21 - dwell counters restart on each bus acquisition
`ifndef DMA_REGS_DEFS_SVH
`define DMA_REGS_DEFS_SVH
`define A_POINTER 5'h00
`define A_MODE 5'h01
`define A_CONTROL 5'h03
`define A_ARRAY 5'h04
`define A_DWELL 5'h09
`define A_VECTOR 5'h0A
`define A_IRQCTL 5'h0C
`define A_IRQCLR 5'h0D
`define A_IRQSET 5'h0E
`define A_ARM 5'h0F
`define A_COUNT 5'h15
`define A_ADDRLO 5'h16
`define A_ADDRHI 5'h17
`define A_NCOUNT 5'h1D
`define A_NADDRLO 5'h1E
`define A_NADDRHI 5'h1F
`define PTR_LSB 1
`define PTR_MSB 5
`define ORDER_BIT 12
`define ARRAY_TX_LSB 12
`define ARRAY_TX_MSB 15
`define RESET_WORD 16'h0000
`endif

// [src/dma_regs_pkg.sv]
package dma_regs_pkg;
  typedef enum logic [1:0] {
    idle_s = 2'b00,
    owning_s = 2'b01,
    finishing_s = 2'b10
  } dwell_state_t;
endpackage
